// >>> rtl/crc_unit_params.svh
// register offsets, field positions, reset values, polynomials, presets and sector size of the crc unit
`ifndef CRC_UNIT_PARAMS_SVH
`define CRC_UNIT_PARAMS_SVH

`define CRC_CONTROL_ADDR    8'h92
`define CRC_RESULT_ADDR     8'h91
`define CRC_INPUT_ADDR      8'h93
`define CRC_AUTO_ADDR       8'h96
`define CRC_COUNT_ADDR      8'h97
`define CRC_SEL_BIT         4
`define CRC_INIT_BIT        3
`define CRC_VAL_BIT         2
`define CRC_AUTO_FLASH_ENABLE_BIT      7
`define CRC_DONE_BIT        6
`define CRC_CONTROL_RESET   8'h00
`define CRC_AUTO_RESET      8'h40
`define CRC_POLY16          16'h1021
`define CRC_POLY32_REFL     32'hedb88320
`define CRC_PRESET_ZERO     32'h00000000
`define CRC_PRESET_ONES     32'hffffffff
`define CRC_SECTOR_BYTES    1024
`define CRC_SECTOR_SHIFT    10

`endif

// >>> rtl/crc_unit_pkg.sv
// types shared by the crc unit
package crc_unit_pkg;
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } sfr_req_t;

    typedef struct packed {
        logic        rdEn;
        logic [15:0] addr;
    } flash_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_FOLD  = 3'b100
    } scan_state_t;
endpackage

// >>> rtl/crc_unit.sv
// byte-serial crc engine with automatic flash sector scan
//
// Function
// - sel 0 uses 0x04C11DB7 with 32-bit result, sel 1 uses 0x1021 16-bit.
// - writing init strobe loads result with zeros or ones per init-value select.
// - every byte written to input register is folded into result immediately.
// - 2-bit pointer picks result byte and advances after every port access.
// - 32-bit mode pointer 0..3 maps to bits 7-0,15-8,23-16,31-24.
// - 16-bit mode pointer 01 maps bits 15-8; others map bits 7-0.
// - result holds until init, port overwrite, new input byte or scanned flash byte.
// - auto mode folds consecutive 1024-byte sectors from start sector for count.
// - with auto enable set and count non-zero, any control write starts flash scan.
// - cpu execution stalls until whole multi-sector scan has finished.
// - third fetched instruction byte after trigger is not guaranteed.
// - control bits 7 to 5 read zero and ignore writes.
// - 16-bit mode xors byte into top bits, shifts left eight times.
// - 32-bit mode xors byte low, shifts right eight times reflected.
// - first scanned address is start sector times 1024.
// - completion flag reads 0 while scanning, 1 otherwise, resets to 1.
`timescale 1ns/1ps
`include "crc_unit_params.svh"

module crc_unit #(
    parameter int FLASH_AW = 16
) (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire crc_unit_pkg::sfr_req_t   sfrReq,
    output logic [7:0]                    sfrRdData,
    output crc_unit_pkg::flash_req_t      flashReq,
    input  wire logic [7:0]               flashData,
    output logic                          cpuStall
);
    import crc_unit_pkg::*;

    // only a 16-bit flash address fits the request struct
    if (FLASH_AW != 16) begin : g_badWidth
        $error("crc_unit: flash address width must be 16");
    end

    // ----------------------------------------------------------------
    // per-byte fold
    // ----------------------------------------------------------------
    function automatic logic [31:0] foldByte(input logic [31:0] acc,
                                             input logic [7:0]  din,
                                             input logic        sel16);
        logic [31:0] a;
        logic [15:0] h;
        a = acc;
        h = acc[15:0];
        if (sel16) begin
            h = h ^ {din, 8'h00};
            for (int i = 0; i < 8; i++) begin
                if (h[15]) begin
                    h = (h << 1) ^ `CRC_POLY16;
                end else begin
                    h = h << 1;
                end
            end
            a = {acc[31:16], h};
        end else begin
            a = a ^ {24'h000000, din};
            for (int i = 0; i < 8; i++) begin
                if (a[0]) begin
                    a = (a >> 1) ^ `CRC_POLY32_REFL;
                end else begin
                    a = a >> 1;
                end
            end
        end
        return a;
    endfunction

    // ----------------------------------------------------------------
    // registers and scan
    // ----------------------------------------------------------------
    logic [31:0]  result_r,   result_nxt;
    logic         sel_r,      sel_nxt;
    logic         val_r,      val_nxt;
    logic [1:0]   ptr_r,      ptr_nxt;
    logic         auto_flash_enable_r,   auto_flash_enable_nxt;
    logic [5:0]   start_r,    start_nxt;
    logic [5:0]   count_r,    count_nxt;
    scan_state_t  state_r,    state_nxt;
    logic [15:0]  addr_r,     addr_nxt;
    logic [16:0]  remain_r,   remain_nxt;
    logic [7:0]   rd_r,       rd_nxt;
    flash_req_t   flash_r,    flash_nxt;
    logic         stall_r,    stall_nxt;
    logic [2:0]   bytePick;
    logic         done;

    assign done = (state_r == ST_IDLE);

    always_comb begin
        bytePick = {1'b0, ptr_r};
        // 16-bit lanes fold to low byte
        if (sel_r && ptr_r != 2'b01) begin
            bytePick = 3'b000;
        end
    end

    always_comb begin
        result_nxt = result_r;
        sel_nxt    = sel_r;
        val_nxt    = val_r;
        ptr_nxt    = ptr_r;
        auto_flash_enable_nxt = auto_flash_enable_r;
        start_nxt  = start_r;
        count_nxt  = count_r;
        state_nxt  = state_r;
        addr_nxt   = addr_r;
        remain_nxt = remain_r;
        rd_nxt     = 8'h00;
        flash_nxt  = '{rdEn: 1'b0, addr: addr_r};
        if (sfrReq.rdEn) begin
            case (sfrReq.addr)
                `CRC_CONTROL_ADDR: rd_nxt = {3'b000, sel_r, 1'b0, val_r, ptr_r};
                `CRC_RESULT_ADDR: begin
                    rd_nxt  = result_r[8*bytePick +: 8];
                    ptr_nxt = ptr_r + 2'b01;
                end
                `CRC_AUTO_ADDR:  rd_nxt = {auto_flash_enable_r, done, start_r};
                `CRC_COUNT_ADDR: rd_nxt = {2'b00, count_r};
                default:         rd_nxt = 8'h00;
            endcase
        end
        if (sfrReq.wrEn && done) begin
            case (sfrReq.addr)
                `CRC_CONTROL_ADDR: begin
                    sel_nxt = sfrReq.wrData[`CRC_SEL_BIT];
                    val_nxt = sfrReq.wrData[`CRC_VAL_BIT];
                    ptr_nxt = sfrReq.wrData[1:0];
                    if (sfrReq.wrData[`CRC_INIT_BIT]) begin
                        result_nxt = sfrReq.wrData[`CRC_VAL_BIT] ? `CRC_PRESET_ONES
                                                                 : `CRC_PRESET_ZERO;
                    end
                    if (auto_flash_enable_r && count_r != 6'h00) begin
                        state_nxt  = ST_FETCH;
                        addr_nxt   = {start_r, 10'h000};
                        remain_nxt = 17'({count_r, 10'h000});
                    end
                end
                `CRC_RESULT_ADDR: begin
                    result_nxt[8*bytePick +: 8] = sfrReq.wrData;
                    ptr_nxt = ptr_r + 2'b01;
                end
                `CRC_INPUT_ADDR: result_nxt = foldByte(result_r, sfrReq.wrData, sel_r);
                `CRC_AUTO_ADDR: begin
                    auto_flash_enable_nxt = sfrReq.wrData[`CRC_AUTO_FLASH_ENABLE_BIT];
                    start_nxt  = sfrReq.wrData[5:0];
                end
                `CRC_COUNT_ADDR: count_nxt = sfrReq.wrData[5:0];
                default: ;
            endcase
        end
        case (state_r)
            ST_IDLE: ;
            ST_FETCH: begin
                flash_nxt = '{rdEn: 1'b1, addr: addr_r};
                state_nxt = ST_FOLD;
            end
            ST_FOLD: begin
                // same fold path as software bytes
                result_nxt = foldByte(result_r, flashData, sel_r);
                addr_nxt   = addr_r + 16'h0001;
                remain_nxt = remain_r - 17'h00001;
                state_nxt  = (remain_r == 17'h00001) ? ST_IDLE : ST_FETCH;
            end
            default: state_nxt = ST_IDLE;
        endcase
        stall_nxt = (state_nxt != ST_IDLE);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result_r  <= `CRC_PRESET_ZERO;
            sel_r     <= 1'b0;
            val_r     <= 1'b0;
            ptr_r     <= 2'b00;
            auto_flash_enable_r  <= 1'b0;
            start_r   <= 6'h00;
            count_r   <= 6'h00;
            state_r   <= ST_IDLE;
            addr_r    <= 16'h0000;
            remain_r  <= 17'h00000;
            rd_r      <= 8'h00;
            flash_r   <= '0;
            stall_r   <= 1'b0;
        end else begin
            result_r  <= result_nxt;
            sel_r     <= sel_nxt;
            val_r     <= val_nxt;
            ptr_r     <= ptr_nxt;
            auto_flash_enable_r  <= auto_flash_enable_nxt;
            start_r   <= start_nxt;
            count_r   <= count_nxt;
            state_r   <= state_nxt;
            addr_r    <= addr_nxt;
            remain_r  <= remain_nxt;
            rd_r      <= rd_nxt;
            flash_r   <= flash_nxt;
            stall_r   <= stall_nxt;
        end
    end

    // stall asserts the cycle after trigger; fetch in flight is not guarded
    assign sfrRdData = rd_r;
    assign flashReq  = flash_r;
    assign cpuStall  = stall_r;
endmodule

// >>> testbench/crc_unit_chk.sv
// port assertions for the crc unit
`timescale 1ns/1ps
module crc_unit_chk (
    input wire logic                     ref_clk,
    input wire logic                     nrst,
    input wire crc_unit_pkg::sfr_req_t   sfrReq,
    input wire logic [7:0]               sfrRdData,
    input wire crc_unit_pkg::flash_req_t flashReq,
    input wire logic [7:0]               flashData,
    input wire logic                     cpuStall
);
    import crc_unit_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_ctlWrite; sfrReq.wrEn && sfrReq.addr == 8'h92; endsequence
    sequence s_fetchPair; flashReq.rdEn ##2 flashReq.rdEn; endsequence
    property p_ctlZero;
        sfrReq.rdEn && sfrReq.addr == 8'h92 |=> sfrRdData[7:5] == 3'b000;
    endproperty
    a_ctlZero: assert property (p_ctlZero) else $error("control top bits set");
    property p_doneIdle;
        sfrReq.rdEn && sfrReq.addr == 8'h96 && !cpuStall |=> sfrRdData[6];
    endproperty
    a_doneIdle: assert property (p_doneIdle) else $error("done low while idle");
    property p_stallCause;
        $rose(cpuStall) |-> $past(sfrReq.wrEn) && $past(sfrReq.addr) == 8'h92;
    endproperty
    a_stallCause: assert property (p_stallCause) else $error("stall without trigger");
    property p_firstFetch;
        s_ctlWrite ##1 $rose(cpuStall) |=> flashReq.rdEn && flashReq.addr[9:0] == 10'h000;
    endproperty
    a_firstFetch: assert property (p_firstFetch) else $error("first fetch off sector");
    property p_ascend;
        s_fetchPair |-> flashReq.addr == $past(flashReq.addr, 2) + 16'h0001;
    endproperty
    a_ascend: assert property (p_ascend) else $error("fetch not ascending");
    property p_spacing; flashReq.rdEn |=> !flashReq.rdEn; endproperty
    a_spacing: assert property (p_spacing) else $error("fetch too close");
    property p_fetchInStall; flashReq.rdEn |-> cpuStall; endproperty
    a_fetchInStall: assert property (p_fetchInStall) else $error("fetch without stall");
    // last fetch stands in the cycle just before the stall drops
    property p_stallEnd;
        $fell(cpuStall) |-> $past(flashReq.rdEn);
    endproperty
    a_stallEnd: assert property (p_stallEnd) else $error("stall ended early");
endmodule

bind crc_unit crc_unit_chk uChk (.ref_clk(ref_clk), .nrst(nrst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .flashReq(flashReq), .flashData(flashData), .cpuStall(cpuStall));

// >>> testbench/flash_model.sv
// flash stand-in: answers a read in its request cycle, junk otherwise
`timescale 1ns/1ps
module flash_model (
    input  wire logic                     ref_clk,
    input  wire crc_unit_pkg::flash_req_t flashReq,
    output logic [7:0]                    flashData
);
    import crc_unit_pkg::*;
    logic [7:0]  junk_r  = 8'ha5;
    always_ff @(posedge ref_clk) begin
        junk_r  <= junk_r + 8'h5b;
    end
    // the engine folds at the edge that ends its request cycle, so answer then;
    // junk, not the last byte, so an early or late sample is caught
    assign flashData = flashReq.rdEn ? (flashReq.addr[7:0] ^ flashReq.addr[15:8]) : junk_r;
endmodule

// >>> testbench/crc_unit_test.sv
// self-checking bench for the crc unit
`timescale 1ns/1ps
module crc_unit_test;
    import crc_unit_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst    = 1'b0;
    sfr_req_t    sfrReq  = '0;
    logic [7:0]  sfrRdData, flashData, rd, ctl, d;
    flash_req_t  flashReq;
    logic        cpuStall;
    logic [31:0] crc;
    int          n_errors = 0;
    int          checks   = 0;
    int          seed     = 71;

    crc_unit dut (.ref_clk(ref_clk), .nrst(nrst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
                  .flashReq(flashReq), .flashData(flashData), .cpuStall(cpuStall));
    flash_model flash (.ref_clk(ref_clk), .flashReq(flashReq), .flashData(flashData));

    always #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one strobe cycle; read data stands the cycle after
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(posedge ref_clk) #1 sfrReq = '{w, !w, a, dat};
        @(posedge ref_clk) #1 sfrReq = '0;
        rd = sfrRdData;
    endtask

    function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] b,
                                         input logic s16);
        if (s16) c[15:8] ^= b;
        else c[7:0] ^= b;
        for (int i = 0; i < 8; i++)
            if (s16) c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
            else c = (c >> 1) ^ (c[0] ? 32'hedb88320 : 32'h00000000);
        return c;
    endfunction

    function automatic logic [7:0] pick(input logic [31:0] c, input logic [1:0] p,
                                        input logic s16);
        if (s16) return (p == 2'h1) ? c[15:8] : c[7:0];
        return c[8*p +: 8];
    endfunction

    task automatic readAll(input int s, input logic s16);
        for (int p = s; p < s + 4; p++) begin
            acc(1'b0, 8'h91, 8'h00);
            chk(rd, pick(crc, 2'(p), s16));
        end
    endtask

    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        #1 nrst = 1'b1;
        acc(1'b0, 8'h96, 8'h00);
        chk(rd, 8'h40);
        acc(1'b0, 8'h92, 8'h00);
        chk(rd, 8'h00);
        // every width and preset; first four check the bare preset
        for (int m = 0; m < 8; m++) begin
            ctl = 8'($random(seed));
            ctl[4:0] = {m[0], 1'b1, m[1], 2'b00};
            crc = m[1] ? 32'hffffffff : 32'h00000000;
            acc(1'b1, 8'h92, ctl);
            acc(1'b0, 8'h92, 8'h00);
            chk(rd, {3'b000, ctl[4], 1'b0, ctl[2], 2'b00});
            repeat (m[2] ? m : 0) begin
                d = 8'($random(seed));
                acc(1'b1, 8'h93, d);
                crc = fold(crc, d, ctl[4]);
            end
            readAll(0, ctl[4]);
            d = 8'($random(seed));
            acc(1'b1, 8'h91, d);
            crc[7:0] = d;
            readAll(1, ctl[4]);
        end
        // known answer, independent of the bench fold
        acc(1'b1, 8'h92, 8'h0c);
        acc(1'b1, 8'h93, 8'h63);
        crc = 32'hf9462090;
        readAll(0, 1'b0);
        // start sector 3, one sector, 32-bit from all ones
        acc(1'b1, 8'h92, 8'h0c);
        crc = 32'hffffffff;
        acc(1'b1, 8'h96, 8'h83);
        acc(1'b1, 8'h97, 8'h01);
        acc(1'b1, 8'h92, 8'h04);
        for (int a = 3072; a < 4096; a++) crc = fold(crc, 8'(a) ^ 8'(a >> 8), 1'b0);
        chk(cpuStall, 1'b1);
        for (int i = 0; i < 3000 && cpuStall === 1'b1; i++) #8;
        chk(cpuStall, 1'b0);
        // harmless non-zero write to the unused address 0x95 follows the scan
        acc(1'b1, 8'h95, 8'h01);
        acc(1'b0, 8'h96, 8'h00);
        chk(rd, 8'hc3);
        acc(1'b1, 8'h96, 8'h03);
        acc(1'b1, 8'h92, 8'h04);
        readAll(0, 1'b0);
        // second reset in mid-run brings the idle auto state back
        @(posedge ref_clk) #1 nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1'b1;
        acc(1'b0, 8'h96, 8'h00);
        chk(rd, 8'h40);
        acc(1'b0, 8'h97, 8'h00);
        chk(rd, 8'h00);
        end_sim();
    end

    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule
